/* File: rtl/tsx_pkg.sv */
// Package for the three-instruction execution block: offsets, opcodes, states and carriers.
// Assumes a single pclk domain and an APB master with 32-bit data.
package tsx_pkg;

	// ==========================================================================
	// Register offsets (byte addresses, one aligned word each; the holding window spans eight words)
	// ==========================================================================
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_INSTR = 8'h04;
	localparam logic [7:0] OFF_WREG = 8'h08;
	localparam logic [7:0] OFF_TLAT = 8'h0c;
	localparam logic [7:0] OFF_TPTR = 8'h10;
	localparam logic [7:0] OFF_BANK = 8'h14;
	localparam logic [7:0] OFF_FSR2 = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [7:0] OFF_MADDR = 8'h20;
	localparam logic [7:0] OFF_MDATA = 8'h24;
	localparam logic [7:0] OFF_HOLD = 8'h40;
	localparam logic [7:0] HOLD_MASK = 8'he0;

	// ==========================================================================
	// Field positions
	// ==========================================================================
	localparam int CTRL_START = 0;
	localparam int CTRL_EXT = 1;
	localparam int CTRL_TWO_WORD = 2;
	localparam int ST_BUSY = 0;
	localparam int ST_SKIP = 1;
	localparam int ST_NEG = 2;
	localparam int ST_ZERO = 3;
	localparam int ST_ILLEGAL = 4;
	localparam int ST_CYCLES = 8;
	localparam int ST_EADDR = 16;

	// ==========================================================================
	// Opcode patterns, addressing constants and Q phase codes
	// ==========================================================================
	localparam logic [13:0] OPC_TABLE_WR_HI = 14'h0003;
	localparam logic [6:0] OPC_TST_HI = 7'h33;
	localparam logic [7:0] OPC_XORL_HI = 8'h0a;
	localparam logic [1:0] TW_NONE = 2'h0;
	localparam logic [1:0] TW_POST_INC = 2'h1;
	localparam logic [1:0] TW_POST_DEC = 2'h2;
	localparam logic [1:0] TW_PRE_INC = 2'h3;
	localparam logic [7:0] ILO_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [1:0] Q1 = 2'h0;
	localparam logic [1:0] Q2 = 2'h1;
	localparam logic [1:0] Q3 = 2'h2;
	localparam logic [1:0] Q4 = 2'h3;

	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [21:0] RST_TPTR = 22'h000000;
	localparam logic [15:0] RST_INSTR = 16'h0000;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [3:0] {
		TSX_IDLE = 4'b0001,
		TSX_CYC1 = 4'b0010,
		TSX_CYC2 = 4'b0100,
		TSX_DUMMY = 4'b1000
	} tsx_state_t;

	typedef struct packed {
		logic is_table_wr;
		logic is_tst;
		logic is_xorl;
		logic [1:0] tw_mode;
		logic bank_acc;
		logic [7:0] lo;
	} tsx_dec_t;

	typedef struct packed {
		logic skip;
		logic neg;
		logic zero;
		logic illegal;
	} tsx_flags_t;

endpackage : tsx_pkg

/* File: rtl/tsx_core.sv */
// Execution unit for table write, test-and-skip-if-zero and literal XOR, with APB registers.
// Assumes an APB master on pclk; software loads an opcode and operands, then starts it.
//
// How it works
// - Post-increment table write stores latch at current pointer, then pointer plus one.
// - Pre-increment table write bumps pointer first, then stores latch at new pointer.
// - Test-and-skip opcode upper byte 0110 011a; low byte is register address.
// - Zero register discards prefetched instruction as a no-op; no flags change (the code sets the skip flag; N and Z keep their values).
// - Skip over a two-word instruction makes three cycles in total.
// - Each added skip cycle is a dummy cycle doing nothing in all phases.
// - Test-and-skip first cycle: decode, read register, process, no write.
// - Bank bit 0 uses the access bank; 1 uses the bank select register.
// - Bank bit 0, extended mode, address up to 95: indexed literal offset.
// - Literal XOR opcode upper byte 0000 1010; low byte is the literal.
// - Literal XOR writes working register XOR literal back, single cycle.
// - Literal XOR updates only negative and zero flags from its result.
//
// The implementer's own choices: the APB interface to the registers and the address map.
module tsx_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic done
);

	// ==========================================================================
	// Storage
	// ==========================================================================
	// Data memory holds 256 bytes; every effective address reads it through its low byte.
	logic [7:0] data_mem [0:255];
	logic [7:0] holding [0:7];
	tsx_pkg::tsx_state_t state_r, state_nxt;
	logic [1:0] phase_r;
	logic [1:0] dummy_r;
	logic [3:0] cycles_r;
	logic [15:0] instr_r;
	logic [7:0] wreg_r, tlat_r, bank_r, maddr_r, opnd_r, latch_r;
	logic [21:0] tptr_r;
	logic [11:0] fsr2_r, eaddr_r;
	logic ext_r, two_word_r, done_r;
	tsx_pkg::tsx_flags_t flags_r;

	// ==========================================================================
	// Helper functions
	// ==========================================================================
	// Banked effective address of a file-register operand.
	function automatic logic [11:0] tsx_eaddr(input logic [7:0] f, input logic a,
			input logic ext, input logic [7:0] bank_sel, input logic [11:0] fsr2);
		logic [11:0] r;
		r = {bank_sel[3:0], f};
		if (!a && ext && f <= tsx_pkg::ILO_LIMIT) begin
			r = fsr2 + {4'h0, f};
		end else if (!a && f < tsx_pkg::ACCESS_SPLIT) begin
			r = {4'h0, f};
		end else if (!a) begin
			r = {tsx_pkg::ACCESS_HIGH_BANK, f};
		end
		return r;
	endfunction : tsx_eaddr

	// Opcode decode into a carrier.
	function automatic tsx_pkg::tsx_dec_t tsx_decode(input logic [15:0] op);
		tsx_pkg::tsx_dec_t d;
		d.is_table_wr = (op[15:2] == tsx_pkg::OPC_TABLE_WR_HI);
		d.is_tst = (op[15:9] == tsx_pkg::OPC_TST_HI);
		d.is_xorl = (op[15:8] == tsx_pkg::OPC_XORL_HI);
		d.tw_mode = op[1:0];
		d.bank_acc = op[8];
		d.lo = op[7:0];
		return d;
	endfunction : tsx_decode

	// ==========================================================================
	// Decode and bus selection
	// ==========================================================================
	// APB access and register hits.
	tsx_pkg::tsx_dec_t dec;
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire busy = (state_r != tsx_pkg::TSX_IDLE);
	wire hit_ctrl = (paddr == tsx_pkg::OFF_CTRL);
	wire hit_instr = (paddr == tsx_pkg::OFF_INSTR);
	wire hit_wreg = (paddr == tsx_pkg::OFF_WREG);
	wire hit_tlat = (paddr == tsx_pkg::OFF_TLAT);
	wire hit_tptr = (paddr == tsx_pkg::OFF_TPTR);
	wire hit_bank = (paddr == tsx_pkg::OFF_BANK);
	wire hit_fsr2 = (paddr == tsx_pkg::OFF_FSR2);
	wire hit_stat = (paddr == tsx_pkg::OFF_STATUS);
	wire hit_maddr = (paddr == tsx_pkg::OFF_MADDR);
	wire hit_mdata = (paddr == tsx_pkg::OFF_MDATA);
	wire hit_hold = ((paddr & tsx_pkg::HOLD_MASK) == tsx_pkg::OFF_HOLD) && (paddr[1:0] == 2'h0);
	wire mapped = hit_ctrl | hit_instr | hit_wreg | hit_tlat | hit_tptr | hit_bank | hit_fsr2
		| hit_stat | hit_maddr | hit_mdata | hit_hold;
	// Operand registers are frozen while an instruction runs so execution sees stable inputs.
	wire sw_wr = wr && !busy;
	wire start = sw_wr && hit_ctrl && pwdata[tsx_pkg::CTRL_START];
	assign dec = tsx_decode(instr_r);
	wire [11:0] ea = tsx_eaddr(dec.lo, dec.bank_acc, ext_r, bank_r, fsr2_r);
	wire [7:0] xor_res = wreg_r ^ opnd_r;
	wire [21:0] tptr_inc = tptr_r + 22'h000001;
	wire [21:0] tptr_dec = tptr_r - 22'h000001;
	wire at_q4 = (phase_r == tsx_pkg::Q4);
	wire tw_pre = dec.is_table_wr && (dec.tw_mode == tsx_pkg::TW_PRE_INC);
	wire tw_post_inc = dec.is_table_wr && (dec.tw_mode == tsx_pkg::TW_POST_INC);
	wire tw_post_dec = dec.is_table_wr && (dec.tw_mode == tsx_pkg::TW_POST_DEC);
	wire in_cyc1 = (state_r == tsx_pkg::TSX_CYC1);
	wire in_cyc2 = (state_r == tsx_pkg::TSX_CYC2);
	wire tst_zero = dec.is_tst && (opnd_r == 8'h00);

	// ==========================================================================
	// Sequencer
	// ==========================================================================
	// Next instruction-cycle state, taken at the end of Q4, or on start when idle.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			tsx_pkg::TSX_IDLE: begin
				if (start) begin
					state_nxt = tsx_pkg::TSX_CYC1;
				end
			end
			tsx_pkg::TSX_CYC1: begin
				if (at_q4 && dec.is_table_wr) begin
					state_nxt = tsx_pkg::TSX_CYC2;
				end else if (at_q4 && tst_zero) begin
					state_nxt = tsx_pkg::TSX_DUMMY;
				end else if (at_q4) begin
					state_nxt = tsx_pkg::TSX_IDLE;
				end
			end
			tsx_pkg::TSX_CYC2: begin
				if (at_q4) begin
					state_nxt = tsx_pkg::TSX_IDLE;
				end
			end
			tsx_pkg::TSX_DUMMY: begin
				if (at_q4 && dummy_r == 2'h1) begin
					state_nxt = tsx_pkg::TSX_IDLE;
				end
			end
			default: begin
				state_nxt = tsx_pkg::TSX_IDLE;
			end
		endcase
	end

	// State, Q phase and instruction-cycle count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= tsx_pkg::TSX_IDLE;
			phase_r <= tsx_pkg::Q1;
			cycles_r <= 4'h0;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			phase_r <= busy ? phase_r + 2'h1 : tsx_pkg::Q1;
			done_r <= busy && (state_nxt == tsx_pkg::TSX_IDLE);
			if (start) begin
				cycles_r <= 4'h0;
			end else if (busy && at_q4) begin
				cycles_r <= cycles_r + 4'h1;
			end
		end
	end

	// Dummy cycles owed after a skip: one, or two when a two-word instruction is dropped.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dummy_r <= 2'h0;
		end else if (in_cyc1 && at_q4 && tst_zero) begin
			dummy_r <= two_word_r ? 2'h2 : 2'h1;
		end else if (state_r == tsx_pkg::TSX_DUMMY && at_q4) begin
			dummy_r <= dummy_r - 2'h1;
		end
	end

	// ==========================================================================
	// Execution datapath
	// ==========================================================================
	// Q2 operand fetch: register or literal in cycle one, table latch in cycle two.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opnd_r <= tsx_pkg::RST_BYTE;
			latch_r <= tsx_pkg::RST_BYTE;
			eaddr_r <= 12'h000;
		end else if (in_cyc1 && phase_r == tsx_pkg::Q2 && dec.is_tst) begin
			opnd_r <= data_mem[ea[7:0]];
			eaddr_r <= ea;
		end else if (in_cyc1 && phase_r == tsx_pkg::Q2) begin
			opnd_r <= dec.lo;
		end else if (in_cyc2 && phase_r == tsx_pkg::Q2) begin
			latch_r <= tlat_r;
		end
	end

	// Working register and flags; the test-and-skip never touches N or Z.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wreg_r <= tsx_pkg::RST_BYTE;
			flags_r <= '0;
		end else if (in_cyc1 && at_q4 && dec.is_xorl) begin
			wreg_r <= xor_res;
			flags_r.neg <= xor_res[7];
			flags_r.zero <= (xor_res == 8'h00);
		end else if (in_cyc1 && at_q4) begin
			flags_r.skip <= tst_zero;
			flags_r.illegal <= !(dec.is_table_wr || dec.is_tst || dec.is_xorl);
		end else if (sw_wr && hit_wreg) begin
			wreg_r <= pwdata[7:0];
		end
	end

	// Table pointer: pre-increment in Q2 of cycle two, post-adjust after the Q4 write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tptr_r <= tsx_pkg::RST_TPTR;
		end else if (in_cyc2 && phase_r == tsx_pkg::Q2 && tw_pre) begin
			tptr_r <= tptr_inc;
		end else if (in_cyc2 && at_q4 && tw_post_inc) begin
			tptr_r <= tptr_inc;
		end else if (in_cyc2 && at_q4 && tw_post_dec) begin
			tptr_r <= tptr_dec;
		end else if (sw_wr && hit_tptr) begin
			tptr_r <= pwdata[21:0];
		end
	end

	// Holding register write in Q4 of cycle two at the pointer value of that moment.
	always_ff @(posedge pclk) begin
		if (in_cyc2 && at_q4) begin
			holding[tptr_r[2:0]] <= latch_r;
		end
	end

	// Data memory is filled by software only; execution just reads it.
	always_ff @(posedge pclk) begin
		if (sw_wr && hit_mdata) begin
			data_mem[maddr_r] <= pwdata[7:0];
		end
	end

	// ==========================================================================
	// Software registers
	// ==========================================================================
	// Plain operand and control registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_r <= tsx_pkg::RST_INSTR;
			tlat_r <= tsx_pkg::RST_BYTE;
			bank_r <= tsx_pkg::RST_BYTE;
			maddr_r <= tsx_pkg::RST_BYTE;
			fsr2_r <= 12'h000;
			ext_r <= 1'b0;
			two_word_r <= 1'b0;
		end else if (sw_wr) begin
			if (hit_instr) begin
				instr_r <= pwdata[15:0];
			end
			if (hit_tlat) begin
				tlat_r <= pwdata[7:0];
			end
			if (hit_bank) begin
				bank_r <= {4'h0, pwdata[3:0]};
			end
			if (hit_maddr) begin
				maddr_r <= pwdata[7:0];
			end
			if (hit_fsr2) begin
				fsr2_r <= pwdata[11:0];
			end
			if (hit_ctrl) begin
				ext_r <= pwdata[tsx_pkg::CTRL_EXT];
				two_word_r <= pwdata[tsx_pkg::CTRL_TWO_WORD];
			end
		end
	end

	// ==========================================================================
	// APB read path
	// ==========================================================================
	// Read mux; unmapped addresses read zero and raise pslverr.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_ctrl) begin
			rd_mux = {29'h0, two_word_r, ext_r, 1'b0};
		end else if (hit_instr) begin
			rd_mux = {16'h0000, instr_r};
		end else if (hit_wreg) begin
			rd_mux = {24'h000000, wreg_r};
		end else if (hit_tlat) begin
			rd_mux = {24'h000000, tlat_r};
		end else if (hit_tptr) begin
			rd_mux = {10'h000, tptr_r};
		end else if (hit_bank) begin
			rd_mux = {24'h000000, bank_r};
		end else if (hit_fsr2) begin
			rd_mux = {20'h00000, fsr2_r};
		end else if (hit_stat) begin
			rd_mux = {4'h0, eaddr_r, 4'h0, cycles_r, 3'h0, flags_r.illegal, flags_r.zero,
				flags_r.neg, flags_r.skip, busy};
		end else if (hit_maddr) begin
			rd_mux = {24'h000000, maddr_r};
		end else if (hit_mdata) begin
			rd_mux = {24'h000000, data_mem[maddr_r]};
		end else if (hit_hold) begin
			rd_mux = {24'h000000, holding[paddr[4:2]]};
		end
	end

	// Registered answer: pready rises in the second access cycle, so every output is a flop.
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= acc && !pready_r;
			pslverr_r <= acc && !pready_r && !mapped;
			prdata_r <= (acc && !pready_r && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign done = done_r;

endmodule : tsx_core

/* File: verif/tsx_chk_sva.sv */
// Checker for the execution block: APB answer timing and instruction completion window.
// Assumes it is bound to tsx_core and sees only that module's ports.
module tsx_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic done
);
	timeunit 1ns;
	timeprecision 1ns;

	// =====================================================================
	// Decode of the watched requests
	// =====================================================================
	// A start is only issued while idle, so every taken start launches an instruction.
	wire logic taken = psel && penable && !pready;
	wire logic start = taken && pwrite && paddr == tsx_pkg::OFF_CTRL && pwdata[0];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// =====================================================================
	// Properties
	// =====================================================================
	property p_one_wait;
		taken |=> pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("pready late after access");
	property p_rdy_pulse;
		pready |=> !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held too long");
	property p_rdy_in_access;
		pready |-> psel && penable;
	endproperty
	a_rdy_in_access: assert property (p_rdy_in_access) else $error("pready outside access");
	property p_err_with_rdy;
		pslverr |-> pready;
	endproperty
	a_err_with_rdy: assert property (p_err_with_rdy) else $error("pslverr without pready");
	property p_rdata_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
	property p_unmapped;
		taken && !pwrite && paddr == 8'h30 |=> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_done_min;
		start |=> !done [*4];
	endproperty
	a_done_min: assert property (p_done_min) else $error("done before one cycle");
	property p_done_max;
		start |-> ##[5:14] done;
	endproperty
	a_done_max: assert property (p_done_max) else $error("done too late");
	property p_done_pulse;
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done held too long");

	// Main scenarios seen at least once.
	c_start: cover property (start);
	c_done: cover property (done);
	c_err: cover property (pslverr);
endmodule : tsx_chk

/* File: verif/tb.sv */
// Self-checking testbench for the execution block, driven over APB.
// Assumes rtl/tsx_pkg.sv, rtl/tsx_core.sv and verif/tsx_chk_sva.sv are compiled first.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic done;
	logic [31:0] rd;
	logic err;
	int fail_count;
	int checks_done;

	tsx_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .done(done));

	// =====================================================================
	// Clock, 50 ns period
	// =====================================================================
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// =====================================================================
	// Shared tasks
	// =====================================================================
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	// One APB transfer; the answer is taken at the rising edge that sees pready high.
	// Right after an edge the outputs still show their pre-edge values, which is what
	// the slave presented at that edge, so the request is released only then.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 16) begin
				fail_count++;
				summarize();
			end
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rdchk

	// Loads an opcode, starts it and waits for the completion pulse.
	task automatic run(input logic [15:0] op, input logic [31:0] ctl);
		int n;
		n = 0;
		wr(tsx_pkg::OFF_INSTR, {16'h0000, op});
		wr(tsx_pkg::OFF_CTRL, ctl | 32'h1);
		@(negedge pclk);
		while (done !== 1'b1) begin
			n++;
			if (n > 40) begin
				fail_count++;
				summarize();
			end
			@(negedge pclk);
		end
	endtask : run

	// =====================================================================
	// Scenarios
	// =====================================================================
	task automatic t_reset;
		rdchk(tsx_pkg::OFF_STATUS, 32'h0);
		rdchk(tsx_pkg::OFF_TPTR, 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		`CHK(err, 1'b1)
		`CHK(rd, 32'h0)
	endtask : t_reset

	// Chained literal XORs reach a nonzero, a zero and a negative result.
	task automatic t_xor;
		logic [7:0] k [3];
		logic [7:0] w;
		k = '{8'haf, 8'h1a, 8'h80};
		w = 8'hb5;
		wr(tsx_pkg::OFF_WREG, {24'h0, w});
		for (int i = 0; i < 3; i++) begin
			run({tsx_pkg::OPC_XORL_HI, k[i]}, 32'h0);
			w = w ^ k[i];
			rdchk(tsx_pkg::OFF_WREG, {24'h0, w});
			rdchk(tsx_pkg::OFF_STATUS, {20'h0, 4'h1, 4'h0, ~|w, w[7], 2'b00});
		end
	endtask : t_xor

	// Test-and-skip over both banks, indexed offsets and two-word skips; N stays set.
	task automatic t_tst;
		logic [15:0] op [9];
		logic [31:0] ctl [9];
		logic [7:0] mv [9];
		logic [11:0] ea [9];
		logic [3:0] cy [9];
		logic [31:0] ex;
		op = '{16'h6734, 16'h6734, 16'h6734, 16'h6734, 16'h6670, 16'h6610, 16'h6610,
			16'h665f, 16'h6660};
		ctl = '{32'h0, 32'h4, 32'h0, 32'h4, 32'h0, 32'h0, 32'h2, 32'h2, 32'h2};
		mv = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		ea = '{12'h234, 12'h234, 12'h234, 12'h234, 12'hf70, 12'h010, 12'h210, 12'h25f,
			12'hf60};
		cy = '{4'h2, 4'h3, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2};
		wr(tsx_pkg::OFF_BANK, 32'h2);
		wr(tsx_pkg::OFF_FSR2, 32'h200);
		for (int i = 0; i < 9; i++) begin
			wr(tsx_pkg::OFF_MADDR, {24'h0, ea[i][7:0]});
			wr(tsx_pkg::OFF_MDATA, {24'h0, mv[i]});
			run(op[i], ctl[i]);
			// N stays set from the last literal XOR; Z stays clear.
			ex = {4'h0, ea[i], 4'h0, cy[i], 5'h0, 1'b1, ~|mv[i], 1'b0};
			rdchk(tsx_pkg::OFF_STATUS, ex);
		end
		rdchk(tsx_pkg::OFF_WREG, 32'h80);
	endtask : t_tst

	// Post- and pre-increment table writes; a neighbour slot must keep its byte.
	task automatic t_tbl;
		wr(tsx_pkg::OFF_TLAT, 32'h55);
		wr(tsx_pkg::OFF_TPTR, 32'h00a356);
		run(16'h000d, 32'h0);
		rdchk(tsx_pkg::OFF_TPTR, 32'h00a357);
		rdchk(tsx_pkg::OFF_HOLD + 8'h18, 32'h55);
		apb(1'b0, tsx_pkg::OFF_STATUS, 32'h0);
		`CHK(rd[11:8], 4'h2)
		wr(tsx_pkg::OFF_TLAT, 32'hff);
		wr(tsx_pkg::OFF_TPTR, 32'h01389a);
		run(16'h000d, 32'h0);
		wr(tsx_pkg::OFF_TLAT, 32'h34);
		wr(tsx_pkg::OFF_TPTR, 32'h01389a);
		run(16'h000f, 32'h0);
		rdchk(tsx_pkg::OFF_TPTR, 32'h01389b);
		rdchk(tsx_pkg::OFF_HOLD + 8'h0c, 32'h34);
		rdchk(tsx_pkg::OFF_HOLD + 8'h08, 32'hff);
		// Post-decrement and plain forms: slot at the pointer, pointer down one or kept.
		wr(tsx_pkg::OFF_TLAT, 32'h77);
		wr(tsx_pkg::OFF_TPTR, 32'h000005);
		run(16'h000e, 32'h0);
		wr(tsx_pkg::OFF_TLAT, 32'h66);
		run(16'h000c, 32'h0);
		rdchk(tsx_pkg::OFF_TPTR, 32'h000004);
		rdchk(tsx_pkg::OFF_HOLD + 8'h14, 32'h77);
		rdchk(tsx_pkg::OFF_HOLD + 8'h10, 32'h66);
		// An opcode outside the three decoded patterns takes one cycle and is flagged.
		run(16'hffff, 32'h0);
		apb(1'b0, tsx_pkg::OFF_STATUS, 32'h0);
		`CHK(rd[4], 1'b1)
		`CHK(rd[11:8], 4'h1)
	endtask : t_tbl

	// =====================================================================
	// Main sequence
	// =====================================================================
	initial begin
		fail_count = 0;
		checks_done = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_xor();
		t_tst();
		t_tbl();
		summarize();
	end
endmodule : tb

// Checker sits on the top module's ports only.
bind tsx_core tsx_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .done(done));
